//--- fgc_map.vh
// field layout and decode constants for the filter and gain control word
// Operation
// RULE_01 - one fifteen bit control word, bits 15..1
// RULE_02 - bits 15..10 corner code, zero bypasses
// RULE_03 - bit 9 selects low or high power
// RULE_04 - bypass: filter off, amps follow bit 9
// RULE_05 - filtering: amps low, filter follows bit 9
// RULE_06 - host sets bit 9 above 31 MHz
// RULE_07 - host sets bit 9 above 60 MHz bypassed
// RULE_08 - bits 8..2 decode stage gain presets
// RULE_09 - bit 1 disables offset correction loops
// RULE_10 - one setting set drives both channels
// RULE_11 - bypass powers down the filter sections
// RULE_12 - new word applies to all settings together
`ifndef FGC_MAP_VH
`define FGC_MAP_VH
`define FGC_WORD_W 15
`define FGC_WORD_RESET 15'h0000
`define FGC_CODE_MSB 14
`define FGC_CODE_LSB 9
`define FGC_CODE_W 6
`define FGC_PWR_BIT 8
`define FGC_IN_MSB 7
`define FGC_IN_LSB 6
`define FGC_MID_MSB 5
`define FGC_MID_LSB 4
`define FGC_OUT_MSB 3
`define FGC_OUT_LSB 2
`define FGC_POST_BIT 1
`define FGC_OFS_BIT 0
`define FGC_BYPASS_CODE 6'h00
`define FGC_GAIN_W 5
`define FGC_IN_G0 5'h0F
`define FGC_IN_G1 5'h0C
`define FGC_IN_G2 5'h09
`define FGC_IN_G3 5'h09
`define FGC_LATE_G0 5'h15
`define FGC_LATE_G1 5'h12
`define FGC_LATE_G2 5'h0F
`define FGC_LATE_G3 5'h0C
`define FGC_POST_G0 5'h03
`define FGC_POST_G1 5'h09
`define FGC_SEL_RESET 2'h0
`define FGC_BIT_CLEAR 1'b0
`define FGC_BIT_SET 1'b1
`endif

//--- fgc_gain_decode.v
// combinational gain preset decoder for the four amplifier stages
`timescale 1ns/1ns
`default_nettype none
`include "fgc_map.vh"
module fgc_gain_decode (
   input wire [6:0] gain_code,
   output wire [4:0] input_amp_stage_db,
   output wire [4:0] middle_amp_stage_db,
   output wire [4:0] output_amp_stage_db,
   output wire [4:0] post_amp_db
);
   // first stage bottoms out at 9 dB for both upper codes
   function [4:0] fgc_in_gain;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: fgc_in_gain = `FGC_IN_G0;
            2'h1: fgc_in_gain = `FGC_IN_G1;
            2'h2: fgc_in_gain = `FGC_IN_G2;
            default: fgc_in_gain = `FGC_IN_G3;
         endcase
      end
   endfunction
   // middle and output stages share one table
   function [4:0] fgc_late_gain;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: fgc_late_gain = `FGC_LATE_G0;
            2'h1: fgc_late_gain = `FGC_LATE_G1;
            2'h2: fgc_late_gain = `FGC_LATE_G2;
            default: fgc_late_gain = `FGC_LATE_G3;
         endcase
      end
   endfunction
   // field positions here are relative to the 7 bit gain slice
   assign input_amp_stage_db = fgc_in_gain(gain_code[6:5]); // [RULE_08]
   assign middle_amp_stage_db = fgc_late_gain(gain_code[4:3]); // [RULE_08]
   assign output_amp_stage_db = fgc_late_gain(gain_code[2:1]); // [RULE_08]
   assign post_amp_db = gain_code[0] ? `FGC_POST_G1 : `FGC_POST_G0;
endmodule
`default_nettype wire

//--- fgc_control_word.v
// control word holder and decoder for filter, power and gain settings
`timescale 1ns/1ns
`default_nettype none
`include "fgc_map.vh"
// word layout, index 14 is the first bit the host sends:
//   [14:9] corner code in MHz, zero selects bypass
//   [8]    power mode, one asks for high power
//   [7:6]  input stage gain select
//   [5:4]  middle stage gain select
//   [3:2]  output stage gain select
//   [1]    post amplifier gain select
//   [0]    a one stops the offset correction loops
// serial shifting and latching sit outside; this block only ever
// sees a whole word with its load strobe

module fgc_control_word #(
   parameter WORD_W = `FGC_WORD_W
) (
   input wire clk_sys,
   input wire rst,
   input wire word_load,
   input wire [WORD_W-1:0] word_in,
   output reg [WORD_W-1:0] filter_gain_control_word,
   output reg [5:0] filter_corner_mhz,
   output reg filter_bypass,
   output reg filter_enable,
   output reg filter_high_power,
   output reg amp_high_power,
   output reg [4:0] input_amp_stage_db,
   output reg [4:0] middle_amp_stage_db,
   output reg [4:0] output_amp_stage_db,
   output reg [4:0] post_amp_db,
   output reg [1:0] input_amp_stage_sel,
   output reg [1:0] middle_amp_stage_sel,
   output reg [1:0] output_amp_stage_sel,
   output reg post_amp_sel,
   output reg offset_loop_enable
);
   wire [5:0] new_code;
   wire new_bypass;
   wire new_pwr;
   wire [4:0] dec_in;
   wire [4:0] dec_mid;
   wire [4:0] dec_out;
   wire [4:0] dec_post;

   // staged next values, all formed from one word in one place
   reg [WORD_W-1:0] next_filter_gain_control_word;
   reg [5:0] next_filter_corner_mhz;
   reg next_filter_bypass;
   reg next_filter_enable;
   reg next_filter_high_power;
   reg next_amp_high_power;
   reg [4:0] next_input_amp_stage_db;
   reg [4:0] next_middle_amp_stage_db;
   reg [4:0] next_output_amp_stage_db;
   reg [4:0] next_post_amp_db;
   reg [1:0] next_input_amp_stage_sel;
   reg [1:0] next_middle_amp_stage_sel;
   reg [1:0] next_output_amp_stage_sel;
   reg next_post_amp_sel;
   reg next_offset_loop_enable;

   // zero corner code means the filters are bypassed
   function fgc_is_bypass;
      input [5:0] code;
      begin
         fgc_is_bypass = (code == `FGC_BYPASS_CODE);
      end
   endfunction

   // amps go high power only in bypass with the power bit set
   function fgc_amp_hp;
      input bypass;
      input pwr;
      begin
         fgc_amp_hp = bypass & pwr; // [RULE_04] [RULE_05]
      end
   endfunction

   // the filter takes the power bit only while it is filtering
   function fgc_flt_hp;
      input bypass;
      input pwr;
      begin
         fgc_flt_hp = ~bypass & pwr; // [RULE_05]
      end
   endfunction

   // fields taken straight from the incoming word, bit 15 is index 14
   assign new_code = word_in[`FGC_CODE_MSB:`FGC_CODE_LSB]; // [RULE_02]
   assign new_bypass = fgc_is_bypass(new_code); // [RULE_02]
   assign new_pwr = word_in[`FGC_PWR_BIT]; // [RULE_03]

   // gain tables sit in their own module so the middle and output
   // stages share one case list; the decode is purely combinational
   // and only reaches the outputs through the registers below
   fgc_gain_decode u_gain (
      .gain_code(word_in[`FGC_IN_MSB:`FGC_POST_BIT]),
      .input_amp_stage_db(dec_in),
      .middle_amp_stage_db(dec_mid),
      .output_amp_stage_db(dec_out),
      .post_amp_db(dec_post)
   );

   // hold every field unless a load arrives, then take the whole word;
   // one select for all fields keeps old and new from ever mixing
   always @* begin
      next_filter_gain_control_word = filter_gain_control_word;
      next_filter_corner_mhz = filter_corner_mhz;
      next_filter_bypass = filter_bypass;
      next_filter_enable = filter_enable;
      next_filter_high_power = filter_high_power;
      next_amp_high_power = amp_high_power;
      next_input_amp_stage_db = input_amp_stage_db;
      next_middle_amp_stage_db = middle_amp_stage_db;
      next_output_amp_stage_db = output_amp_stage_db;
      next_post_amp_db = post_amp_db;
      next_input_amp_stage_sel = input_amp_stage_sel;
      next_middle_amp_stage_sel = middle_amp_stage_sel;
      next_output_amp_stage_sel = output_amp_stage_sel;
      next_post_amp_sel = post_amp_sel;
      next_offset_loop_enable = offset_loop_enable;
      // a load replaces every field from the one incoming word
      if (word_load) begin
         next_filter_gain_control_word = word_in; // [RULE_01] [RULE_12]
         // one corner code serves both channels
         next_filter_corner_mhz = new_code; // [RULE_02] [RULE_10]
         next_filter_bypass = new_bypass; // [RULE_02]
         // bypass powers the filter sections down entirely
         next_filter_enable = ~new_bypass; // [RULE_04] [RULE_11]
         // amps only go high power while the filter is bypassed
         next_amp_high_power = fgc_amp_hp(new_bypass, new_pwr); // [RULE_04]
         next_filter_high_power = fgc_flt_hp(new_bypass, new_pwr); // [RULE_05]
         next_input_amp_stage_db = dec_in; // [RULE_08] [RULE_10]
         next_middle_amp_stage_db = dec_mid; // [RULE_08]
         next_output_amp_stage_db = dec_out; // [RULE_08]
         next_post_amp_db = dec_post; // [RULE_08]
         next_input_amp_stage_sel = word_in[`FGC_IN_MSB:`FGC_IN_LSB];
         next_middle_amp_stage_sel = word_in[`FGC_MID_MSB:`FGC_MID_LSB];
         next_output_amp_stage_sel = word_in[`FGC_OUT_MSB:`FGC_OUT_LSB];
         next_post_amp_sel = word_in[`FGC_POST_BIT];
         // a one in the flag stops the loops
         next_offset_loop_enable = ~word_in[`FGC_OFS_BIT]; // [RULE_09]
      end
   end

   // reset parks the part in bypass at low power with the offset
   // loops running; every group below shares the same edge, so a
   // load still lands in all of them at once
   // raw word kept for read back
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         filter_gain_control_word <= `FGC_WORD_RESET;
      end else begin
         filter_gain_control_word <= next_filter_gain_control_word;
      end
   end

   // filter corner, bypass and filter power
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         filter_corner_mhz <= `FGC_BYPASS_CODE;
         filter_bypass <= `FGC_BIT_SET;
         filter_enable <= `FGC_BIT_CLEAR;
         filter_high_power <= `FGC_BIT_CLEAR;
      end else begin
         filter_corner_mhz <= next_filter_corner_mhz;
         filter_bypass <= next_filter_bypass;
         filter_enable <= next_filter_enable;
         filter_high_power <= next_filter_high_power;
      end
   end

   // amplifier power mode
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         amp_high_power <= `FGC_BIT_CLEAR;
      end else begin
         amp_high_power <= next_amp_high_power;
      end
   end

   // three stage gains with their raw select codes, shared by both
   // channels, so no per channel copies
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         input_amp_stage_db <= `FGC_IN_G0;
         middle_amp_stage_db <= `FGC_LATE_G0;
         output_amp_stage_db <= `FGC_LATE_G0;
         input_amp_stage_sel <= `FGC_SEL_RESET;
         middle_amp_stage_sel <= `FGC_SEL_RESET;
         output_amp_stage_sel <= `FGC_SEL_RESET;
      end else begin
         input_amp_stage_db <= next_input_amp_stage_db;
         middle_amp_stage_db <= next_middle_amp_stage_db;
         output_amp_stage_db <= next_output_amp_stage_db;
         input_amp_stage_sel <= next_input_amp_stage_sel;
         middle_amp_stage_sel <= next_middle_amp_stage_sel;
         output_amp_stage_sel <= next_output_amp_stage_sel;
      end
   end

   // post amplifier gain
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         post_amp_db <= `FGC_POST_G0;
         post_amp_sel <= `FGC_BIT_CLEAR;
      end else begin
         post_amp_db <= next_post_amp_db;
         post_amp_sel <= next_post_amp_sel;
      end
   end

   // offset correction loops run out of reset
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         offset_loop_enable <= `FGC_BIT_SET;
      end else begin
         offset_loop_enable <= next_offset_loop_enable;
      end
   end
endmodule
`default_nettype wire

//--- fgc_control_word_properties.sv
// port checks for the filter and gain control word decoder
`timescale 1ns/1ns
`default_nettype none
module fgc_control_word_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic word_load,
   input wire logic [14:0] word_in,
   input wire logic [14:0] filter_gain_control_word,
   input wire logic filter_bypass,
   input wire logic amp_high_power
);
   wire [14:0] w = filter_gain_control_word; // short alias of the held word
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_ld; word_load; endsequence
   sequence s_hold; s_ld ##1 !word_load; endsequence
   // |=> forms only: a reset pulse between edges aborts the attempt
   load_word_a: assert property (s_ld |=> w == $past(word_in))
      else $error("word not taken on load");
   idle_hold_a: assert property (!word_load |=> $stable(w))
      else $error("word moved without load");
   bypass_code_a: assert property (
      filter_bypass == (w[14:9] == 6'h00))
      else $error("bypass does not follow zero code");
   amp_power_a: assert property (
      amp_high_power == (filter_bypass && w[8]))
      else $error("amp power wrong in bypass");
   amp_low_a: assert property (!filter_bypass |-> !amp_high_power)
      else $error("amps high while filtering");
   bypass_load_a: assert property (
      s_ld |=> filter_bypass == ($past(word_in) < 15'h0200))
      else $error("bypass wrong after load");
   power_load_a: assert property (
      s_ld |=> amp_high_power == (($past(word_in) >> 8) == 15'h0001))
      else $error("power mode wrong after load");
   load_hold_a: assert property (
      s_hold |=> $stable(filter_bypass) && $stable(amp_high_power))
      else $error("settings moved after load");
endmodule
bind fgc_control_word fgc_control_word_properties u_chk (.*);
`default_nettype wire

//--- fgc_host_model.sv
// host model presenting each control word after a falling clock edge
`timescale 1ns/1ns
`default_nettype none
module fgc_host_model (
   input wire logic clk_sys,
   input wire logic [15:0] req_word,
   output var logic word_load = 1'b0,
   output var logic [14:0] word_in = 15'h0000
);
   // idle word flips each cycle so a stray take cannot hide
   always @(negedge clk_sys) begin
      word_load <= req_word[15];
      word_in <= req_word[15] ? req_word[14:0] : ~word_in;
   end
endmodule
`default_nettype wire

//--- tb_fgc_control_word.sv
// corner and random control words through the host, checked in full
`timescale 1ns/1ns
`default_nettype none
module tb_fgc_control_word;
   logic clk_sys = 1'b0, rst = 1'b1;
   logic [15:0] rw = 16'h0000;
   int n_fail = 0, samples_checked = 0;
   wire ld;
   wire [14:0] wi;
   wire [52:0] o;
   always #50 clk_sys = ~clk_sys; // 10 MHz
   fgc_host_model u_host (.clk_sys(clk_sys), .req_word(rw),
      .word_load(ld), .word_in(wi));
   fgc_control_word u_dut (.clk_sys(clk_sys), .rst(rst), .word_load(ld),
      .word_in(wi), .filter_gain_control_word(o[52:38]),
      .filter_corner_mhz(o[37:32]), .filter_bypass(o[31]),
      .filter_enable(o[30]), .filter_high_power(o[29]),
      .amp_high_power(o[28]), .input_amp_stage_db(o[27:23]),
      .middle_amp_stage_db(o[22:18]), .output_amp_stage_db(o[17:13]),
      .post_amp_db(o[12:8]), .input_amp_stage_sel(o[7:6]),
      .middle_amp_stage_sel(o[5:4]), .output_amp_stage_sel(o[3:2]),
      .post_amp_sel(o[1]), .offset_loop_enable(o[0]));
   // every output worked out from the word alone
   function automatic logic [52:0] dec(input logic [14:0] w);
      dec = {w, w[14:9], ~|w[14:9], |w[14:9], |w[14:9] & w[8],
         ~|w[14:9] & w[8], w[7] ? 5'h09 : w[6] ? 5'h0C : 5'h0F,
         5'h15 - 5'h03 * w[5:4], 5'h15 - 5'h03 * w[3:2],
         w[1] ? 5'h09 : 5'h03, w[7:1], ~w[0]};
   endfunction
   task automatic chk(input logic [52:0] seen, exp);
      samples_checked++;
      n_fail += int'(seen !== exp);
      if (seen !== exp)
         $display("wrong value outputs expected %h seen %h", exp, seen);
   endtask
   // host lifts the power bit for wide corners; in bypass the random
   // power bit stands for a channel wider than the filter range
   task automatic send(input logic [14:0] w);
      logic [14:0] sent;
      sent = {w[14:9], w[14] | w[8], w[7:0]};
      @(posedge clk_sys);
      rw <= {1'b1, sent};
      @(posedge clk_sys);
      rw[15] <= 1'b0;
      @(negedge clk_sys);
      chk(o, dec(sent));
   endtask
   task automatic give_verdict;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h5C56));
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      chk(o, dec(15'h0000));
      for (int i = 0; i < 160; i++)
         send(i < 2 ? {15{i[0]}} : i == 2 ? 15'h3E00 : i == 3 ? 15'h01FE
            : 15'($urandom));
      rst = 1'b1;
      @(negedge clk_sys);
      chk(o, dec(15'h0000));
      rst = 1'b0;
      chk(o, dec(15'h0000));
      for (int i = 0; i < 4; i++)
         send(15'($urandom));
      give_verdict;
   end
   // about 33 us expected; cut a hang well after that
   initial begin
      #1000000 n_fail++;
      give_verdict;
   end
endmodule
`default_nettype wire
